// File: common/mtc_pkg.sv
// measurement trigger and calculation: constants, register map and types
// assumes a 200 MHz core clock and a plain strobe register port
//
// Overview of operation
// - default: no triggering, continuous data output
// - triggering never alters the measurement cycle rate
// - source: two pins, software, encoder, inactive
// - level mode: output while level present
// - level polarity and edge direction selectable
// - edge starts burst of count or infinite
// - software start 1..16383 or infinite, stop
// - encoder limits and step give single triggers
// - encoder mode: no readings between step positions
// - record mode: process values only after trigger
// - output mode: compute always except in encoder mode, trigger gates output
// - record and output gating share one timing
// - trigger time difference output five cycles later
// - exposure ends 100 ns after cycle start
// - each calc block runs one program
// - difference program outputs A minus B
// - sum: f1*A plus f2*B plus offset
// - duplicate program copies its input
// - two sources for sums, one for averages
// - depths: recursive 2..32000, moving 2..4096, median 3..9
// - depth sets how many values are combined
// - moving average: mean of last N, N a power of two
// - recursive: (new + (N-1)*avg) / N
// - median: middle of last N sorted
`default_nettype none
package mtc_pkg;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TRIG_MIN_US   = 5;
  localparam int TRIG_MIN_CYC  = (TRIG_MIN_US * 1000000) / CLK_PERIOD_PS;
  localparam int EXP_END_NS    = 100;
  localparam int EXP_END_CYC   = (EXP_END_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TDIFF_DLY     = 5;
  localparam int MED_MAX       = 9;
  localparam int MOV_AW        = 12;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_COUNT  = 8'h04;
  localparam logic [7:0] OFS_CMD    = 8'h08;
  localparam logic [7:0] OFS_PERIOD = 8'h0c;
  localparam logic [7:0] OFS_ENC_LO = 8'h10;
  localparam logic [7:0] OFS_ENC_HI = 8'h14;
  localparam logic [7:0] OFS_STEP   = 8'h18;
  localparam logic [7:0] OFS_CALC   = 8'h1c;
  localparam logic [7:0] OFS_DEPTH  = 8'h20;
  localparam logic [7:0] OFS_FAC    = 8'h24;
  localparam logic [7:0] OFS_OFFS   = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2c;
  localparam logic [7:0] OFS_TDIFF  = 8'h30;

  localparam int CTRL_POL  = 3;
  localparam int CTRL_EDGE = 4;
  localparam int CTRL_OUTM = 5;
  localparam int CTRL_ENC  = 6;
  localparam int CMD_START = 0;
  localparam int CMD_STOP  = 1;
  localparam int CNT_INF   = 14;

  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [14:0] COUNT_RST = 15'h0001;
  localparam logic [3:0]  CALC_RST  = 4'h3;
  localparam logic [14:0] DEPTH_RST = 15'h0004;
  localparam logic [31:0] FAC_RST   = 32'h0001_0001;

  typedef enum logic [2:0] {MTC_OFF, MTC_PIN_SYNC, MTC_PIN_DED, MTC_SOFT, MTC_ENC} mtc_src_e;
  typedef enum logic [1:0] {MTC_DIFF, MTC_SUM, MTC_DUP, MTC_AVG} mtc_prog_e;
  typedef enum logic [1:0] {MTC_MOV, MTC_REC, MTC_MED} mtc_avg_e;

  typedef struct packed {
    logic        valid;
    logic [31:0] a;
    logic [31:0] b;
  } mtc_sample_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] value;
    logic [23:0] tdiff;
  } mtc_result_s;
endpackage : mtc_pkg
`default_nettype wire

// File: design/mtc_top.sv
// measurement trigger gate, trigger time difference and calculation block
// assumes samples arrive on core_clk, encoder positions are core_clk counts
`timescale 1ns/10ps
`default_nettype none
module mtc_top
#(
  parameter logic [23:0] PERIOD_DEF = 24'd200000
)
(
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // register port
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               reg_rdata,
  // trigger pins and encoders
  input  wire logic                 sync_trig_in,
  input  wire logic                 dedicated_trigger_input,
  input  wire logic [2:0][31:0]     enc_pos,
  // measurement stream
  input  wire mtc_pkg::mtc_sample_s smp,
  output mtc_pkg::mtc_result_s      res,
  // cycle timing
  output logic                      cycle_start,
  output logic                      exposure_end,
  output logic                      record_en
);
  import mtc_pkg::*;

  localparam int ExpD = EXP_END_CYC;

  typedef struct packed {
    logic [7:0]       ctrl;
    logic [14:0]      count;
    logic [23:0]      period;
    logic [31:0]      enc_lo;
    logic [31:0]      enc_hi;
    logic [31:0]      enc_step;
    logic [3:0]       calc;
    logic [14:0]      depth;
    logic [31:0]      fac;
    logic [31:0]      offs;
    logic [31:0]      rdata;
    logic [1:0]       s1;
    logic [1:0]       s2;
    logic [1:0]       s3;
    logic [23:0]      cnt;
    logic [23:0]      tcap;
    logic [4:0][23:0] tp;
    logic             pend;
    logic             gate;
    logic             inf;
    logic [13:0]      rem;
    logic [31:0]      enc_next;
    logic [47:0]      msum;
    logic [11:0]      wp;
    logic [12:0]      fill;
    logic [31:0]      ravg;
    logic             rfirst;
    logic [8:0][31:0] med;
    mtc_result_s      res;
  } mtc_state_s;

  mtc_state_s q;
  mtc_state_s d;
  logic [31:0] mov_mem [0:(1<<MOV_AW)-1];

  // log2 of a power-of-two window; non powers round down
  function automatic logic [3:0] mtc_log2(input logic [14:0] n);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 1; i <= MOV_AW; i++)
    begin
      if (n[i])
        r = 4'(i);
    end
    return r;
  endfunction : mtc_log2

  // rank selection: entry with exactly n/2 smaller peers
  function automatic logic [31:0] mtc_median(input logic [8:0][31:0] w,
                                             input logic [3:0] n);
    logic [31:0] r;
    logic [3:0]  rank;
    r = w[0];
    for (int i = 0; i < MED_MAX; i++)
    begin
      rank = 4'h0;
      for (int j = 0; j < MED_MAX; j++)
      begin
        if (j < int'(n) && j != i &&
            ($signed(w[j]) < $signed(w[i]) || (w[j] == w[i] && j < i)))
          rank = rank + 4'h1;
      end
      if (i < int'(n) && rank == (n >> 1))
        r = w[i];
    end
    return r;
  endfunction : mtc_median

  mtc_src_e    src;
  mtc_prog_e   prog;
  mtc_avg_e    avgt;
  logic        cstart;
  logic        sel;
  logic        lvl_act;
  logic        hw_edge;
  logic        enc_hit;
  logic        soft_go;
  logic        stop_cmd;
  logic        ev;
  logic        upd;
  logic        wr_avg;
  logic [31:0] pos;
  logic [31:0] old;
  logic [31:0] mov;
  logic [31:0] rec;
  logic [31:0] medv;
  logic [31:0] val;
  logic [47:0] nsum;
  logic [63:0] sumv;
  logic [63:0] rnum;
  logic [15:0] rn;
  logic [8:0][31:0] win;

  assign src          = mtc_src_e'(q.ctrl[2:0]);
  assign prog         = mtc_prog_e'(q.calc[1:0]);
  assign avgt         = mtc_avg_e'(q.calc[3:2]);
  assign cstart       = (q.cnt == 24'h0);
  assign cycle_start  = cstart;
  assign exposure_end = (q.cnt == 24'(EXP_END_CYC));
  assign record_en    = q.gate;
  assign reg_rdata    = q.rdata;
  assign res          = q.res;

  always_comb
  begin
    d = q;
    // two flops per pin, third stage only for edge detection
    d.s1 = {dedicated_trigger_input, sync_trig_in};
    d.s2 = q.s1;
    d.s3 = q.s2;
    sel = (src == MTC_PIN_DED);
    lvl_act = (q.s2[sel] == q.ctrl[CTRL_POL]);
    hw_edge = (q.s2[sel] != q.s3[sel]) && lvl_act;

    // free-running cycle counter, untouched by any trigger setting
    d.cnt = (q.cnt + 24'h1 >= q.period) ? 24'h0 : q.cnt + 24'h1;

    // encoder window with step positions
    pos = enc_pos[q.ctrl[CTRL_ENC +: 2] == 2'h2 ? 2 : (q.ctrl[CTRL_ENC] ? 1 : 0)];
    enc_hit = (src == MTC_ENC) && $signed(pos) >= $signed(q.enc_lo) &&
              $signed(pos) <= $signed(q.enc_hi) &&
              $signed(pos) >= $signed(q.enc_next);
    if (src == MTC_ENC && $signed(pos) < $signed(q.enc_lo))
      d.enc_next = q.enc_lo;
    else if (enc_hit)
      d.enc_next = q.enc_next + q.enc_step;

    // register writes
    stop_cmd = reg_wr && reg_addr == OFS_CMD && reg_wdata[CMD_STOP];
    soft_go  = reg_wr && reg_addr == OFS_CMD && reg_wdata[CMD_START] &&
               !stop_cmd && src == MTC_SOFT;
    wr_avg   = reg_wr && (reg_addr == OFS_CALC || reg_addr == OFS_DEPTH);
    if (reg_wr)
    begin
      case (reg_addr)
        OFS_CTRL:   d.ctrl     = reg_wdata[7:0];
        OFS_COUNT:  d.count    = reg_wdata[14:0];
        OFS_PERIOD: d.period   = reg_wdata[23:0];
        OFS_ENC_LO: d.enc_lo   = reg_wdata;
        OFS_ENC_HI: d.enc_hi   = reg_wdata;
        OFS_STEP:   d.enc_step = reg_wdata;
        OFS_CALC:   d.calc     = reg_wdata[3:0];
        OFS_DEPTH:  d.depth    = reg_wdata[14:0];
        OFS_FAC:    d.fac      = reg_wdata;
        OFS_OFFS:   d.offs     = reg_wdata;
        default:    d.ctrl     = q.ctrl;
      endcase
    end

    // register reads, data stands in the following cycle only
    d.rdata = 32'h0;
    if (reg_rd)
    begin
      case (reg_addr)
        OFS_CTRL:   d.rdata = {24'h0, q.ctrl};
        OFS_COUNT:  d.rdata = {17'h0, q.count};
        OFS_PERIOD: d.rdata = {8'h0, q.period};
        OFS_ENC_LO: d.rdata = q.enc_lo;
        OFS_ENC_HI: d.rdata = q.enc_hi;
        OFS_STEP:   d.rdata = q.enc_step;
        OFS_CALC:   d.rdata = {28'h0, q.calc};
        OFS_DEPTH:  d.rdata = {17'h0, q.depth};
        OFS_FAC:    d.rdata = q.fac;
        OFS_OFFS:   d.rdata = q.offs;
        OFS_STATUS: d.rdata = {2'h0, q.rem, 13'h0, q.pend, q.inf, q.gate};
        OFS_TDIFF:  d.rdata = {8'h0, q.tp[TDIFF_DLY-1]};
        default:    d.rdata = 32'h0;
      endcase
    end

    // trigger event; a new event wins over consumption
    ev = soft_go || enc_hit ||
         (hw_edge && q.ctrl[CTRL_EDGE] &&
          (src == MTC_PIN_SYNC || src == MTC_PIN_DED));
    if (ev)
      d.tcap = q.cnt;
    if (stop_cmd)
    begin
      d.rem = 14'h0;
      d.inf = 1'b0;
    end
    d.pend = ev || (q.pend && !cstart && !stop_cmd);

    // gate decided once per measurement cycle
    if (cstart)
    begin
      d.tp = {q.tp[TDIFF_DLY-2:0], q.tcap};
      case (src)
        MTC_OFF: d.gate = 1'b1;
        MTC_ENC: d.gate = q.pend;
        MTC_PIN_SYNC, MTC_PIN_DED, MTC_SOFT:
        begin
          if (src != MTC_SOFT && !q.ctrl[CTRL_EDGE])
            d.gate = lvl_act;
          else if (q.pend)
          begin
            d.gate = 1'b1;
            d.inf  = q.count[CNT_INF];
            d.rem  = (q.count[CNT_INF] || q.count[13:0] == 14'h0) ? 14'h0
                     : q.count[13:0] - 14'h1;
          end
          else if (q.inf)
            d.gate = 1'b1;
          else if (q.rem != 14'h0)
          begin
            d.gate = 1'b1;
            d.rem  = q.rem - 14'h1;
          end
          else
            d.gate = 1'b0;
        end
        default: d.gate = 1'b0;
      endcase
    end

    // record mode processes only gated values; output mode all values,
    // except encoder mode where nothing is taken between positions
    upd = smp.valid && (q.gate || (q.ctrl[CTRL_OUTM] && src != MTC_ENC));

    // moving average over a power-of-two window
    old  = (q.fill >= q.depth[12:0]) ?
           mov_mem[q.wp - q.depth[11:0]] : 32'h0;
    nsum = q.msum + {{16{smp.a[31]}}, smp.a} - {{16{old[31]}}, old};
    mov  = 32'($signed(nsum) >>> mtc_log2(q.depth));

    // recursive average; division kept exact at the cost of a divider
    rn   = (q.depth == 15'h0) ? 16'h1 : {1'b0, q.depth};
    rnum = 64'($signed(smp.a)) + 64'($signed({1'b0, rn - 16'h1})) * 64'($signed(q.ravg));
    rec  = q.rfirst ? smp.a : 32'($signed(rnum) / $signed({48'h0, rn}));

    // median over the newest entries of a nine-deep window
    win  = {q.med[7:0], smp.a};
    medv = mtc_median(win, q.depth[3:0]);

    sumv = 64'($signed(q.fac[15:0]) * $signed(smp.a)) +
           64'($signed(q.fac[31:16]) * $signed(smp.b)) + 64'($signed(q.offs));
    case (prog)
      MTC_DIFF: val = smp.a - smp.b;
      MTC_SUM:  val = sumv[31:0];
      MTC_DUP:  val = smp.a;
      MTC_AVG:
      begin
        case (avgt)
          MTC_MOV: val = mov;
          MTC_REC: val = rec;
          MTC_MED: val = medv;
          default: val = smp.a;
        endcase
      end
      default:  val = smp.a;
    endcase

    if (upd && prog == MTC_AVG)
    begin
      d.msum   = nsum;
      d.wp     = q.wp + 12'h1;
      d.fill   = q.fill[12] ? q.fill : q.fill + 13'h1;
      d.ravg   = rec;
      d.rfirst = 1'b0;
      d.med    = win;
    end
    if (wr_avg)
    begin
      d.msum   = 48'h0;
      d.wp     = 12'h0;
      d.fill   = 13'h0;
      d.rfirst = 1'b1;
    end

    // same gate and latency in both modes
    d.res.valid = upd && q.gate;
    d.res.value = val;
    d.res.tdiff = q.tp[TDIFF_DLY-1];
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      q        <= '0;
      q.ctrl   <= CTRL_RST;
      q.count  <= COUNT_RST;
      q.period <= PERIOD_DEF;
      q.calc   <= CALC_RST;
      q.depth  <= DEPTH_RST;
      q.fac    <= FAC_RST;
      q.rfirst <= 1'b1;
    end
    else
      q <= d;
  end

  // window storage, no reset needed: fill count masks stale entries
  always_ff @(posedge core_clk)
  begin
    if (upd && prog == MTC_AVG)
      mov_mem[q.wp] <= smp.a;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_off_gate_open: assert property (cstart && src == MTC_OFF |=> q.gate)
    else $error("gate closed while triggering is off");
  a_cycle_rate: assert property (cstart && q.period > 24'h2 |=> !cstart [*2])
    else $error("cycle restarted early");
  a_exposure_end: assert property (cstart && q.period > 24'(ExpD) |-> ##ExpD exposure_end)
    else $error("exposure end not at fixed offset");
  a_level_gate: assert property (cstart && src == MTC_PIN_SYNC && !q.ctrl[CTRL_EDGE]
                                 |=> q.gate == $past(lvl_act))
    else $error("level gate does not follow pin");
  a_burst_load: assert property (cstart && q.pend && src == MTC_SOFT && !stop_cmd &&
                                 !q.count[CNT_INF] && q.count[13:0] != 14'h0
                                 |=> q.gate && q.rem == $past(q.count[13:0]) - 14'h1)
    else $error("burst count not loaded");
  a_stop_cmd: assert property (stop_cmd && !cstart |=> q.rem == 14'h0 && !q.inf)
    else $error("stop command ignored");
  a_enc_single: assert property (cstart && src == MTC_ENC && !q.pend |=> !q.gate)
    else $error("encoder gate without trigger");
  a_out_gated: assert property (q.res.valid |-> $past(q.gate && smp.valid))
    else $error("output without gate");
  a_diff_value: assert property (smp.valid && q.gate && prog == MTC_DIFF
                                 |=> q.res.valid && q.res.value == $past(smp.a - smp.b))
    else $error("difference wrong");
  a_tdiff_pipe: assert property (cstart |=> q.tp[0] == $past(q.tcap))
    else $error("tdiff pipe");

  c_level_run: cover property (src == MTC_PIN_DED && q.gate ##1 !q.gate);
  c_burst_done: cover property (q.rem == 14'h1 ##[1:1000] q.rem == 14'h0);
  c_enc_hit: cover property (enc_hit ##1 q.pend);
  c_median_out: cover property (q.res.valid && avgt == MTC_MED && prog == MTC_AVG);
endmodule : mtc_top
`default_nettype wire

// File: sim/mtc_trig_src.sv
// trigger source model: drives both trigger pins of the block
// assumes the bench calls its tasks; pins change right after rising edges
`timescale 1ns/10ps
`default_nettype none
module mtc_trig_src
(
  // clock
  input  wire logic core_clk,
  // trigger pins
  output logic      sync_trig_in,
  output logic      dedicated_trigger_input
);
  import mtc_pkg::*;

  initial
  begin
    sync_trig_in = 1'b0;
    dedicated_trigger_input = 1'b0;
  end

  task automatic set_pin(input bit sel, input logic lvl);
    @(posedge core_clk);
    if (sel)
      dedicated_trigger_input <= lvl;
    else
      sync_trig_in <= lvl;
  endtask : set_pin

  // stretched to the minimum width, which covers 25 of the 40-clock bench measurement cycles
  task automatic pulse(input bit sel, input logic lvl, input int cyc);
    int n;
    n = (cyc < TRIG_MIN_CYC) ? TRIG_MIN_CYC : cyc;
    set_pin(sel, lvl);
    repeat (n - 1) @(posedge core_clk);
    set_pin(sel, !lvl);
  endtask : pulse
endmodule : mtc_trig_src
`default_nettype wire

// File: sim/measurement_trigger_and_calc_tb.sv
// self-checking bench: register port, calc programs, trigger gating
// assumes mtc_top with a short measurement period of 40 clocks
`timescale 1ns/10ps
`default_nettype none
module measurement_trigger_and_calc_tb;
  import mtc_pkg::*;
  localparam int P = 40;
  logic             core_clk;
  logic             rst_n;
  logic [7:0]       reg_addr;
  logic [31:0]      reg_wdata;
  logic             reg_wr;
  logic             reg_rd;
  logic [31:0]      reg_rdata;
  logic             sync_trig_in;
  logic             dedicated_trigger_input;
  logic [2:0][31:0] enc_pos;
  mtc_sample_s      smp;
  mtc_result_s      res;
  logic             cycle_start;
  logic             exposure_end;
  logic             record_en;
  int               error_cnt;
  int               compares;

  mtc_top #(.PERIOD_DEF(24'd40)) u_mtc_top (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_trig_in(sync_trig_in),
    .dedicated_trigger_input(dedicated_trigger_input), .enc_pos(enc_pos), .smp(smp),
    .res(res), .cycle_start(cycle_start), .exposure_end(exposure_end), .record_en(record_en));

  mtc_trig_src u_mtc_trig_src (.core_clk(core_clk), .sync_trig_in(sync_trig_in),
    .dedicated_trigger_input(dedicated_trigger_input));

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic test_done();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    @(negedge core_clk);
    check(what, reg_rdata, exp);
  endtask : rdc

  // result is registered one cycle after the sample pulse
  task automatic send(input logic [31:0] a, input logic [31:0] b, input logic [31:0] exp);
    @(posedge core_clk);
    smp <= '{valid: 1'b1, a: a, b: b};
    @(posedge core_clk);
    smp.valid <= 1'b0;
    @(negedge core_clk);
    check("res_valid", {31'h0, res.valid}, 32'h1);
    check("res_value", res.value, exp);
  endtask : send

  // sample offered while the gate is closed: no result may appear
  task automatic quiet(input logic [31:0] a);
    @(posedge core_clk);
    smp <= '{valid: 1'b1, a: a, b: 32'h0};
    @(posedge core_clk);
    smp.valid <= 1'b0;
    @(negedge core_clk);
    check("res_quiet", {31'h0, res.valid}, 32'h0);
  endtask : quiet

  task automatic wait_cs();
    int i;
    i = 0;
    do @(negedge core_clk); while (cycle_start !== 1'b1 && ++i < 2 * P);
    check("cycle_start", {31'h0, cycle_start}, 32'h1);
  endtask : wait_cs

  task automatic count(input int n, output int g, output int c);
    g = 0;
    c = 0;
    repeat (n)
    begin
      @(negedge core_clk);
      if (record_en === 1'b1)
        g++;
      if (cycle_start === 1'b1)
        c++;
    end
  endtask : count

  task automatic t_reset();
    rdc("ctrl", OFS_CTRL, 32'(CTRL_RST));
    rdc("count", OFS_COUNT, 32'(COUNT_RST));
    rdc("period", OFS_PERIOD, 32'(P));
    rdc("calc", OFS_CALC, 32'(CALC_RST));
    rdc("depth", OFS_DEPTH, 32'(DEPTH_RST));
    rdc("fac", OFS_FAC, FAC_RST);
    rdc("offs", OFS_OFFS, 32'h0);
    rdc("unmapped", 8'h40, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_calc();
    int i;
    for (i = 1; i <= 4; i++)
      send(32'h8, 32'h0, 32'(2 * i));
    wr(OFS_CALC, 32'h7);
    wr(OFS_DEPTH, 32'h2);
    // first value after a clear seeds the recursive average
    send(32'h8, 32'h0, 32'h8);
    send(32'h4, 32'h0, 32'h6);
    wr(OFS_CALC, 32'hb);
    wr(OFS_DEPTH, 32'h3);
    // median window still holds 4, 8 from the recursive run
    send(32'h2, 32'h0, 32'h4);
    send(32'h9, 32'h0, 32'h4);
    send(32'h1, 32'h0, 32'h2);
    send(32'h5, 32'h0, 32'h5);
    wr(OFS_CALC, 32'h0);
    send(32'ha, 32'h4, 32'h6);
    wr(OFS_CALC, 32'h1);
    wr(OFS_FAC, 32'h0003_0002);
    wr(OFS_OFFS, 32'h5);
    send(32'ha, 32'h4, 32'h25);
    wr(OFS_CALC, 32'h2);
    send(32'h1234, 32'h77, 32'h1234);
    $display("test calc done");
  endtask : t_calc

  task automatic t_timing();
    int i;
    wait_cs();
    i = 0;
    do @(negedge core_clk); while (exposure_end !== 1'b1 && ++i < 2 * P);
    check("exposure_end", 32'(i + 1), 32'(EXP_END_CYC));
    $display("test timing done");
  endtask : t_timing

  task automatic t_soft();
    int g;
    int c;
    wr(OFS_CTRL, 32'h3);
    wr(OFS_COUNT, 32'h2);
    wait_cs();
    wr(OFS_CMD, 32'h1);
    count(8 * P, g, c);
    check("soft_gate", 32'(g), 32'(2 * P));
    check("soft_rate", 32'(c), 32'h8);
    wr(OFS_COUNT, 32'h4000);
    wr(OFS_CMD, 32'h1);
    wait_cs();
    wait_cs();
    count(4 * P, g, c);
    check("inf_gate", 32'(g), 32'(4 * P));
    rdc("status", OFS_STATUS, 32'h3);
    wr(OFS_CMD, 32'h2);
    wait_cs();
    count(4 * P, g, c);
    check("stop_gate", 32'(g), 32'h0);
    $display("test soft done");
  endtask : t_soft

  task automatic t_pins();
    int g;
    int c;
    wr(OFS_CTRL, 32'h09);
    wait_cs();
    fork
      u_mtc_trig_src.pulse(1'b0, 1'b1, 1000);
      count(1200, g, c);
    join
    check("level_gate", 32'(g), 32'd1000);
    u_mtc_trig_src.set_pin(1'b1, 1'b1);
    wr(OFS_COUNT, 32'h1);
    wr(OFS_CTRL, 32'h12);
    wait_cs();
    fork
      u_mtc_trig_src.pulse(1'b1, 1'b0, 1000);
      count(1200, g, c);
    join
    check("edge_gate", 32'(g), 32'(P));
    // pin fell as the count left cycle start, edge seen two clocks later at count 3
    rdc("tdiff", OFS_TDIFF, 32'h3);
    $display("test pins done");
  endtask : t_pins

  task automatic t_gate();
    wr(OFS_CTRL, 32'h03);
    wr(OFS_CALC, 32'h3);
    wr(OFS_DEPTH, 32'h2);
    quiet(32'h8);
    wr(OFS_CMD, 32'h1);
    wait_cs();
    send(32'h4, 32'h0, 32'h2);
    check("tdiff_out", {8'h0, res.tdiff}, 32'h3);
    wr(OFS_CTRL, 32'h23);
    wr(OFS_DEPTH, 32'h2);
    wait_cs();
    quiet(32'h8);
    wr(OFS_CMD, 32'h1);
    wait_cs();
    send(32'h4, 32'h0, 32'h6);
    $display("test gate done");
  endtask : t_gate

  task automatic t_enc();
    int g;
    int c;
    wr(OFS_ENC_LO, 32'd100);
    wr(OFS_ENC_HI, 32'd300);
    wr(OFS_STEP, 32'd100);
    wr(OFS_CTRL, 32'h24);
    wr(OFS_DEPTH, 32'h2);
    wait_cs();
    quiet(32'h8);
    @(posedge core_clk);
    enc_pos[0] <= 32'd150;
    wait_cs();
    send(32'h4, 32'h0, 32'h2);
    wait_cs();
    count(2 * P, g, c);
    check("enc_idle", 32'(g), 32'h0);
    @(posedge core_clk);
    enc_pos[0] <= 32'd250;
    wait_cs();
    count(P, g, c);
    check("enc_step", 32'(g), 32'(P));
    $display("test enc done");
  endtask : t_enc

  initial
  begin
    repeat (10000) @(posedge core_clk);
    error_cnt++;
    test_done();
  end

  initial
  begin
    error_cnt = 0;
    compares  = 0;
    rst_n     = 1'b0;
    reg_addr  = 8'h0;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    enc_pos   = '0;
    smp       = '0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_calc();
    t_timing();
    t_soft();
    t_pins();
    t_gate();
    t_enc();
    test_done();
  end
endmodule : measurement_trigger_and_calc_tb
`default_nettype wire
